// [hdl/asc_defs.vh]
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_A_DATA 3'h0
`define ASC_A_IER 3'h1
`define ASC_A_ISR 3'h2
`define ASC_A_LCR 3'h3
`define ASC_A_MCR 3'h4
`define ASC_A_LSR 3'h5
`define ASC_A_MSR 3'h6
`define ASC_A_SCR 3'h7
`define ASC_LCR_DLAB 7
`define ASC_LCR_BRK 6
`define ASC_LCR_STICK 5
`define ASC_LCR_EPS 4
`define ASC_LCR_PEN 3
`define ASC_LCR_STB 2
`define ASC_MCR_LOOP 4
`define ASC_MCR_IRQ_EN 3
`define ASC_IER_RX 0
`define ASC_IER_TX 1
`define ASC_IER_LS 2
`define ASC_IER_MS 3
`define ASC_ISR_NONE 8'h01
`define ASC_ISR_LS 8'h06
`define ASC_ISR_RX 8'h04
`define ASC_ISR_TX 8'h02
`define ASC_ISR_MS 8'h00
`define ASC_LSR_RST 8'h60
`define ASC_DIV_RST 8'h01
`define ASC_SYNC_RST 19'h7FFFF
`define ASC_START_MID 4'h7
`define ASC_BIT_LAST 4'hF
`define ASC_STOP1_LAST 6'h0F
`define ASC_STOP15_LAST 6'h17
`define ASC_STOP2_LAST 6'h1F
`endif

// [hdl/asc_baud.v]
`timescale 1ns/1ps
`include "asc_defs.vh"
module asc_baud (
   input wire clk,
   input wire srst,
   input wire [15:0] div,
   output reg tick
);
   reg [15:0] cnt_ff;

   // Divisor zero acts as one
   always @(posedge clk) begin
      if (srst) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_ff + 16'h0001 >= div) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// [hdl/asc_rx.v]
`timescale 1ns/1ps
`include "asc_defs.vh"
module asc_rx (
   input wire clk,
   input wire srst,
   input wire tick,
   input wire rxd,
   input wire [1:0] wlen,
   input wire pen,
   input wire eps,
   input wire stick,
   output reg done,
   output reg [7:0] data,
   output reg perr,
   output reg ferr,
   output reg brk
);
   localparam S_IDLE = 3'h0;
   localparam S_START = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_PAR = 3'h3;
   localparam S_STOP = 3'h4;
   reg [2:0] st_ff;
   reg [3:0] cnt_ff;
   reg [2:0] nbit_ff;
   reg [7:0] sh_ff;
   reg par_ff;
   reg pe_ff;
   reg zero_ff;
   reg prev_ff;
   wire [2:0] last_bit = {1'b0, wlen} + 3'h4;
   wire mid = tick && (cnt_ff == `ASC_BIT_LAST);

   always @(posedge clk) begin
      if (srst) begin
         st_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         nbit_ff <= 3'h0;
         sh_ff <= 8'h00;
         par_ff <= 1'b0;
         pe_ff <= 1'b0;
         zero_ff <= 1'b0;
         prev_ff <= 1'b1;
         done <= 1'b0;
         data <= 8'h00;
         perr <= 1'b0;
         ferr <= 1'b0;
         brk <= 1'b0;
      end else begin
         done <= 1'b0;
         prev_ff <= rxd;
         if (tick)
            cnt_ff <= cnt_ff + 4'h1;
         case (st_ff)
            S_IDLE: begin
               // Edge needed: a held break does not restart
               if (prev_ff && !rxd) begin
                  st_ff <= S_START;
                  cnt_ff <= 4'h0;
               end
            end
            S_START: begin
               if (tick && cnt_ff == `ASC_START_MID) begin
                  cnt_ff <= 4'h0;
                  nbit_ff <= 3'h0;
                  par_ff <= 1'b0;
                  pe_ff <= 1'b0;
                  zero_ff <= 1'b1;
                  st_ff <= rxd ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               if (mid) begin
                  sh_ff <= {rxd, sh_ff[7:1]};
                  par_ff <= par_ff ^ rxd;
                  zero_ff <= zero_ff & ~rxd;
                  nbit_ff <= nbit_ff + 3'h1;
                  if (nbit_ff == last_bit)
                     st_ff <= pen ? S_PAR : S_STOP;
               end
            end
            S_PAR: begin
               if (mid) begin
                  pe_ff <= stick ? (rxd ^ ~eps) : (par_ff ^ rxd ^ ~eps);
                  zero_ff <= zero_ff & ~rxd;
                  st_ff <= S_STOP;
               end
            end
            S_STOP: begin
               if (mid) begin
                  done <= 1'b1;
                  data <= sh_ff >> (~wlen);
                  perr <= pe_ff;
                  ferr <= ~rxd;
                  brk <= zero_ff & ~rxd;
                  st_ff <= S_IDLE;
               end
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end
endmodule

// [hdl/asc_channel.v]
`timescale 1ns/1ps
`include "asc_defs.vh"
// Contract
// - Holding write loads when holding or shifter empty
// - Holding-empty sets when empty or byte moved
// - Start bit confirmed low at 8 ticks
// - Divisor sets 16x tick; latches need bit 7
// - Enable bits 0-3 gate four sources
// - Identification reports highest pending source
// - Id bit 0 low when pending
// - Format bits 1-0 pick 5 to 8 bits
// - Bit 2 picks one, 1.5 or 2 stops
// - Bit 3 adds parity, bit 4 even
// - Bit 5 forces parity to not bit 4
// - Bit 6 holds output low for break
// - Control bits 0,1 drive terminal/request low
// - Control bit 3 enables interrupt pin
// - Control bit 4 loops transmitter to receiver
// - Loopback takes modem inputs from control bits
// - Status bits 0-4 flag receive conditions
// - Status 5,6 show transmitter empties, 7 zero
// - Change bits set on edges, clear on read
// - Upper bits show inputs; changes raise interrupt
// - Reset clears control, flags empty, none pending
module asc_channel (
   input wire clk,
   input wire srst,
   input wire cs_n,
   input wire ior_n,
   input wire iow_n,
   input wire [2:0] addr,
   input wire [7:0] din,
   output reg [7:0] dout,
   output wire dout_oe,
   output wire rdout,
   input wire rx,
   input wire cts_n,
   input wire dsr_n,
   input wire ri_n,
   input wire cd_n,
   output wire tx,
   output wire dtr_n,
   output wire rts_n,
   output wire irq,
   output wire irq_oe
);
   localparam T_IDLE = 3'h0;
   localparam T_START = 3'h1;
   localparam T_DATA = 3'h2;
   localparam T_PAR = 3'h3;
   localparam T_STOP = 3'h4;

   // All pin inputs pass two flops
   reg [18:0] s1_ff;
   reg [18:0] s2_ff;
   reg [13:0] p_ff;

   reg [7:0] dll_ff;
   reg [7:0] dlm_ff;
   reg [3:0] ier_ff;
   reg [7:0] lcr_ff;
   reg [4:0] mcr_ff;
   reg [7:0] scr_ff;
   reg [7:0] thr_ff;
   reg [7:0] rhr_ff;
   reg thre_ff;
   reg thre_irq_ff;
   reg dr_ff;
   reg oe_ff;
   reg pe_ff;
   reg fe_ff;
   reg bi_ff;
   reg [3:0] dmsr_ff;
   reg [3:0] mprev_ff;
   reg prime_ff;
   reg [7:0] tpar_src_ff;

   reg [2:0] tst_ff;
   reg [2:0] nxt_tst;
   reg [7:0] tsr_ff;
   reg [5:0] tcnt_ff;
   reg [2:0] tbit_ff;
   reg tline_ff;

   wire tick;
   wire rx_done;
   wire [7:0] rx_data;
   wire rx_perr;
   wire rx_ferr;
   wire rx_brk;

   wire [7:0] b_din = s2_ff[7:0];
   wire [2:0] b_addr = s2_ff[10:8];
   wire b_iow_n = s2_ff[11];
   wire b_ior_n = s2_ff[12];
   wire b_cs_n = s2_ff[13];
   wire rx_s = s2_ff[14];
   wire [3:0] m_pin_n = s2_ff[18:15];
   wire [7:0] p_din = p_ff[7:0];
   wire [2:0] p_addr = p_ff[10:8];
   wire p_wr = !p_ff[13] && !p_ff[11];
   wire p_rd = !p_ff[13] && !p_ff[12];
   wire rd_act = !b_cs_n && !b_ior_n;
   wire wr_end = p_wr && (b_iow_n || b_cs_n);
   wire rd_end = p_rd && (b_ior_n || b_cs_n);

   wire dlab = lcr_ff[`ASC_LCR_DLAB];
   wire loop = mcr_ff[`ASC_MCR_LOOP];
   wire [1:0] wlen = lcr_ff[1:0];
   wire tx_idle = (tst_ff == T_IDLE);
   wire temt = thre_ff && tx_idle;
   wire txd_int = lcr_ff[`ASC_LCR_BRK] ? 1'b0 : tline_ff;
   wire rx_in = loop ? txd_int : rx_s;
   wire [3:0] m_now;
   wire [7:0] link_state_flags = {1'b0, temt, thre_ff, bi_ff, fe_ff, pe_ff, oe_ff, dr_ff};
   wire [7:0] handshake_input_state = {m_now[3], m_now[2], m_now[1], m_now[0], dmsr_ff};
   wire [5:0] stop_last;
   wire tick_end;
   wire thr_wr = wr_end && !dlab && (p_addr == `ASC_A_DATA);
   wire thr_take = thre_ff || tx_idle;
   reg [7:0] irq_source_id;
   reg [7:0] rd_mux;

   // Loopback maps request, terminal, bits 2 and 3 onto modem lines
   assign m_now = loop ? {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1]} : ~m_pin_n;

   assign stop_last = !lcr_ff[`ASC_LCR_STB] ? `ASC_STOP1_LAST :
                      (wlen == 2'h0) ? `ASC_STOP15_LAST : `ASC_STOP2_LAST;
   assign tick_end = tick && (tst_ff == T_STOP ? tcnt_ff == stop_last
                                               : tcnt_ff[3:0] == `ASC_BIT_LAST);

   function [7:0] len_mask;
      input [1:0] w;
      begin
         len_mask = 8'hFF >> (~w);
      end
   endfunction

   function tx_par;
      input [7:0] d;
      input [1:0] w;
      input e;
      input s;
      begin
         tx_par = s ? ~e : (^(d & len_mask(w))) ^ ~e;
      end
   endfunction

   asc_baud u_baud (
      .clk(clk),
      .srst(srst),
      .div({dlm_ff, dll_ff}),
      .tick(tick)
   );

   asc_rx u_rx (
      .clk(clk),
      .srst(srst),
      .tick(tick),
      .rxd(rx_in),
      .wlen(wlen),
      .pen(lcr_ff[`ASC_LCR_PEN]),
      .eps(lcr_ff[`ASC_LCR_EPS]),
      .stick(lcr_ff[`ASC_LCR_STICK]),
      .done(rx_done),
      .data(rx_data),
      .perr(rx_perr),
      .ferr(rx_ferr),
      .brk(rx_brk)
   );

   always @(posedge clk) begin
      if (srst) begin
         s1_ff <= `ASC_SYNC_RST;
         s2_ff <= `ASC_SYNC_RST;
         p_ff <= 14'h3FFF;
      end else begin
         s1_ff <= {cd_n, ri_n, dsr_n, cts_n, rx, cs_n, ior_n, iow_n, addr, din};
         s2_ff <= s1_ff;
         p_ff <= s2_ff[13:0];
      end
   end

   // Interrupt sources and priority
   wire src_ls = ier_ff[`ASC_IER_LS] && (oe_ff || pe_ff || fe_ff || bi_ff);
   wire src_rx = ier_ff[`ASC_IER_RX] && dr_ff;
   wire src_tx = ier_ff[`ASC_IER_TX] && thre_irq_ff && thre_ff;
   wire src_ms = ier_ff[`ASC_IER_MS] && (|dmsr_ff);

   always @* begin
      if (src_ls)
         irq_source_id = `ASC_ISR_LS;
      else if (src_rx)
         irq_source_id = `ASC_ISR_RX;
      else if (src_tx)
         irq_source_id = `ASC_ISR_TX;
      else if (src_ms)
         irq_source_id = `ASC_ISR_MS;
      else
         irq_source_id = `ASC_ISR_NONE;
   end

   always @* begin
      case (b_addr)
         `ASC_A_DATA: rd_mux = dlab ? dll_ff : rhr_ff;
         `ASC_A_IER: rd_mux = dlab ? dlm_ff : {4'h0, ier_ff};
         `ASC_A_ISR: rd_mux = irq_source_id;
         `ASC_A_LCR: rd_mux = lcr_ff;
         `ASC_A_MCR: rd_mux = {3'h0, mcr_ff};
         `ASC_A_LSR: rd_mux = link_state_flags;
         `ASC_A_MSR: rd_mux = handshake_input_state;
         `ASC_A_SCR: rd_mux = scr_ff;
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (srst)
         dout <= 8'h00;
      else if (rd_act)
         dout <= rd_mux;
   end

   assign dout_oe = rd_act;
   assign rdout = rd_act;

   // Register writes happen at the trailing edge of the strobe
   always @(posedge clk) begin
      if (srst) begin
         dll_ff <= `ASC_DIV_RST;
         dlm_ff <= 8'h00;
         ier_ff <= 4'h0;
         lcr_ff <= 8'h00;
         mcr_ff <= 5'h00;
         scr_ff <= 8'h00;
      end else if (wr_end) begin
         case (p_addr)
            `ASC_A_DATA: begin
               if (dlab)
                  dll_ff <= p_din;
            end
            `ASC_A_IER: begin
               if (dlab)
                  dlm_ff <= p_din;
               else
                  ier_ff <= p_din[3:0];
            end
            `ASC_A_LCR: lcr_ff <= p_din;
            `ASC_A_MCR: mcr_ff <= p_din[4:0];
            `ASC_A_SCR: scr_ff <= p_din;
            default: ;
         endcase
      end
   end

   // Transmitter state
   always @* begin
      nxt_tst = tst_ff;
      case (tst_ff)
         T_IDLE: if (!thre_ff) nxt_tst = T_START;
         T_START: if (tick_end) nxt_tst = T_DATA;
         T_DATA: begin
            if (tick_end && tbit_ff == {1'b0, wlen} + 3'h4)
               nxt_tst = lcr_ff[`ASC_LCR_PEN] ? T_PAR : T_STOP;
         end
         T_PAR: if (tick_end) nxt_tst = T_STOP;
         T_STOP: if (tick_end) nxt_tst = T_IDLE;
         default: nxt_tst = T_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         tst_ff <= T_IDLE;
         tsr_ff <= 8'h00;
         tcnt_ff <= 6'h00;
         tbit_ff <= 3'h0;
         tline_ff <= 1'b1;
         thr_ff <= 8'h00;
         thre_ff <= 1'b1;
         thre_irq_ff <= 1'b0;
      end else begin
         tst_ff <= nxt_tst;
         if (tick)
            tcnt_ff <= tick_end ? 6'h00 : tcnt_ff + 6'h01;
         // Clear first so a same-cycle move to the shifter wins
         if (rd_end && p_addr == `ASC_A_ISR && dout == `ASC_ISR_TX)
            thre_irq_ff <= 1'b0;
         if (tst_ff == T_IDLE && !thre_ff) begin
            tsr_ff <= thr_ff;
            tcnt_ff <= 6'h00;
            tbit_ff <= 3'h0;
            tline_ff <= 1'b0;
            thre_ff <= 1'b1;
            thre_irq_ff <= 1'b1;
         end else if (tick_end) begin
            case (nxt_tst)
               T_DATA: begin
                  tline_ff <= tsr_ff[0];
                  tsr_ff <= {1'b0, tsr_ff[7:1]};
                  if (tst_ff == T_DATA)
                     tbit_ff <= tbit_ff + 3'h1;
               end
               T_PAR: tline_ff <= tx_par(tpar_src_ff, wlen, lcr_ff[`ASC_LCR_EPS],
                                         lcr_ff[`ASC_LCR_STICK]);
               default: tline_ff <= 1'b1;
            endcase
         end
         if (wr_end && !dlab && p_addr == `ASC_A_IER && p_din[1] && !ier_ff[1] && thre_ff)
            thre_irq_ff <= 1'b1;
         // Full holding register and busy shifter: byte dropped
         if (thr_wr && thr_take) begin
            thr_ff <= p_din;
            thre_ff <= 1'b0;
            thre_irq_ff <= 1'b0;
         end
      end
   end

   // Private parity source: holding register may refill mid-frame
   always @(posedge clk) begin
      if (srst)
         tpar_src_ff <= 8'h00;
      else if (tst_ff == T_IDLE && !thre_ff)
         tpar_src_ff <= thr_ff;
   end

   // Receive flags: set wins over a clearing read
   always @(posedge clk) begin
      if (srst) begin
         rhr_ff <= 8'h00;
         dr_ff <= 1'b0;
         oe_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
         bi_ff <= 1'b0;
      end else begin
         if (rd_end && !dlab && p_addr == `ASC_A_DATA)
            dr_ff <= 1'b0;
         if (rd_end && p_addr == `ASC_A_LSR) begin
            oe_ff <= 1'b0;
            pe_ff <= 1'b0;
            fe_ff <= 1'b0;
            bi_ff <= 1'b0;
         end
         if (rx_done) begin
            rhr_ff <= rx_data;
            dr_ff <= 1'b1;
            if (dr_ff)
               oe_ff <= 1'b1;
            if (rx_perr && lcr_ff[`ASC_LCR_PEN])
               pe_ff <= 1'b1;
            if (rx_ferr)
               fe_ff <= 1'b1;
            if (rx_brk)
               bi_ff <= 1'b1;
         end
      end
   end

   // Modem change detect; first cycle after reset only primes
   always @(posedge clk) begin
      if (srst) begin
         dmsr_ff <= 4'h0;
         mprev_ff <= 4'h0;
         prime_ff <= 1'b0;
      end else begin
         mprev_ff <= m_now;
         prime_ff <= 1'b1;
         if (rd_end && p_addr == `ASC_A_MSR)
            dmsr_ff <= 4'h0;
         if (prime_ff) begin
            if (m_now[0] != mprev_ff[0])
               dmsr_ff[0] <= 1'b1;
            if (m_now[1] != mprev_ff[1])
               dmsr_ff[1] <= 1'b1;
            if (mprev_ff[2] && !m_now[2])
               dmsr_ff[2] <= 1'b1;
            if (m_now[3] != mprev_ff[3])
               dmsr_ff[3] <= 1'b1;
         end
      end
   end

   // Pins
   assign tx = loop ? 1'b1 : txd_int;
   assign dtr_n = ~mcr_ff[0];
   assign rts_n = ~mcr_ff[1];
   assign irq = (irq_source_id != `ASC_ISR_NONE);
   assign irq_oe = mcr_ff[`ASC_MCR_IRQ_EN];
endmodule

// [dv/asc_channel_checker.sv]
`timescale 1ns/1ps
module asc_channel_checker (
   input wire clk,
   input wire srst,
   input wire cs_n,
   input wire ior_n,
   input wire iow_n,
   input wire [7:0] dout,
   input wire dout_oe,
   input wire rdout,
   input wire tx,
   input wire dtr_n,
   input wire rts_n,
   input wire irq,
   input wire irq_oe
);
   reg [3:0] wr_age_ff;
   wire [3:0] nxt_wr_age;
   // Saturates so a long idle never wraps back to a fresh write
   assign nxt_wr_age = (!cs_n && !iow_n) ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hF};
   always @(posedge clk) begin
      if (srst) begin
         wr_age_ff <= 4'hF;
      end else begin
         wr_age_ff <= nxt_wr_age;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_low16;
      !tx[*8] ##1 !tx[*8];
   endsequence
   sequence s_high16;
      tx[*8] ##1 tx[*8];
   endsequence
   sequence s_idle3;
      !dout_oe[*3];
   endsequence
   a_reset_idle: assert property (
      $fell(srst) |-> tx && dtr_n && rts_n && !irq_oe && !irq)
      else $error("outputs not idle after reset");
   a_rdout_same: assert property (rdout == dout_oe)
      else $error("rdout differs from dout_oe");
   a_oe_strobe: assert property (dout_oe == $past(!cs_n && !ior_n, 2))
      else $error("dout_oe not two cycles after read strobe");
   a_dout_hold: assert property (s_idle3 |-> $stable(dout))
      else $error("dout moved outside a read");
   a_ctrl_write: assert property (
      ($changed(dtr_n) || $changed(rts_n)) |-> wr_age_ff < 4'h8)
      else $error("handshake output moved without a write");
   a_irq_en_write: assert property ($changed(irq_oe) |-> wr_age_ff < 4'h8)
      else $error("irq_oe moved without a write");
   a_start_width: assert property ($fell(tx) |-> s_low16)
      else $error("low bit shorter than 16 ticks");
   a_mark_width: assert property ($rose(tx) |-> s_high16)
      else $error("high bit shorter than 16 ticks");
endmodule
bind asc_channel asc_channel_checker chk_u (.clk(clk), .srst(srst), .cs_n(cs_n), .ior_n(ior_n),
   .iow_n(iow_n), .dout(dout), .dout_oe(dout_oe), .rdout(rdout), .tx(tx), .dtr_n(dtr_n),
   .rts_n(rts_n), .irq(irq), .irq_oe(irq_oe));

// [dv/asc_modem_model.sv]
`timescale 1ns/1ps
module asc_modem_model (
   input wire clk,
   input wire tx,
   output logic rx,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic cd_n
);
   int bit_clks = 16;
   int cap_n = 9;
   int cyc = 0;
   int last_fall = 0;
   logic [15:0] shf;
   logic [15:0] got_q[$];
   int gap_q[$];
   initial begin
      rx = 1'b1;
      {cd_n, ri_n, dsr_n, cts_n} = 4'hF;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end
   // Samples at bit centres, start bit not stored
   always begin
      @(negedge tx);
      gap_q.push_back(cyc - last_fall);
      last_fall = cyc;
      shf = 16'h0000;
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < cap_n; i++) begin
         repeat (bit_clks) @(posedge clk);
         shf[i] = tx;
      end
      got_q.push_back(shf);
   end
   task automatic send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx = bits[i];
         repeat (bit_clks - 1) @(negedge clk);
      end
      @(negedge clk);
      rx = 1'b1;
   endtask
   task automatic glitch(input int w);
      @(negedge clk);
      rx = 1'b0;
      repeat (w) @(negedge clk);
      rx = 1'b1;
   endtask
   task automatic set_lines(input logic [3:0] v);
      @(negedge clk);
      {cd_n, ri_n, dsr_n, cts_n} = v;
   endtask
endmodule

// [dv/async_serial_channel_bench.sv]
`timescale 1ns/1ps
`include "asc_defs.vh"
module async_serial_channel_bench;
   logic clk;
   logic srst;
   logic cs_n;
   logic ior_n;
   logic iow_n;
   logic [2:0] addr;
   logic [7:0] din;
   logic [7:0] rv;
   wire [7:0] dout;
   wire dout_oe, rdout, rx, cts_n, dsr_n, ri_n, cd_n, tx, dtr_n, rts_n, irq, irq_oe;
   logic [7:0] lcrs [6] = '{8'h03, 8'h04, 8'h1A, 8'h0D, 8'h2B, 8'h3B};
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   asc_channel dut_u (.clk(clk), .srst(srst), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
      .addr(addr), .din(din), .dout(dout), .dout_oe(dout_oe), .rdout(rdout), .rx(rx),
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .tx(tx), .dtr_n(dtr_n),
      .rts_n(rts_n), .irq(irq), .irq_oe(irq_oe));
   asc_modem_model modem_u (.clk(clk), .tx(tx), .rx(rx), .cts_n(cts_n), .dsr_n(dsr_n),
      .ri_n(ri_n), .cd_n(cd_n));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         finish_test;
      end
   end
   task automatic finish_test;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobes held four cycles, released four, to clear the input synchronisers
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      din = d;
      cs_n = 1'b0;
      iow_n = ~w;
      ior_n = w;
      repeat (4) @(negedge clk);
      {cs_n, iow_n, ior_n} = 3'h7;
      repeat (4) @(negedge clk);
      rv = dout;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk_reg(rv, exp);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         acc(1'b0, `ASC_A_LSR, 8'h00);
         n++;
      end while (rv[6] !== 1'b1 && n < 200);
   endtask
   function automatic logic [15:0] frame(input logic [7:0] char_format_ctrl, input logic [7:0] d);
      logic [7:0] m;
      logic p;
      m = 8'hFF >> (3 - char_format_ctrl[1:0]);
      p = char_format_ctrl[5] ? ~char_format_ctrl[4] : ^(d & m) ^ ~char_format_ctrl[4];
      frame = {8'h00, d & m} | (16'(p & char_format_ctrl[3]) << (5 + char_format_ctrl[1:0]));
      frame = frame | (16'h0001 << (5 + char_format_ctrl[1:0] + char_format_ctrl[3]));
   endfunction
   task automatic t_regs;
      rd(`ASC_A_IER, 8'h00);
      rd(`ASC_A_ISR, `ASC_ISR_NONE);
      rd(`ASC_A_LCR, 8'h00);
      rd(`ASC_A_MCR, 8'h00);
      rd(`ASC_A_LSR, `ASC_LSR_RST);
      wr(`ASC_A_IER, 8'hFF);
      rd(`ASC_A_IER, 8'h0F);
      wr(`ASC_A_SCR, 8'hA5);
      wr(`ASC_A_LSR, 8'h00);
      rd(`ASC_A_SCR, 8'hA5);
      rd(`ASC_A_LSR, `ASC_LSR_RST);
   endtask
   task automatic t_div;
      wr(`ASC_A_IER, 8'h0A);
      wr(`ASC_A_LCR, 8'h83);
      wr(`ASC_A_DATA, 8'h02);
      wr(`ASC_A_IER, 8'h00);
      rd(`ASC_A_DATA, 8'h02);
      rd(`ASC_A_IER, 8'h00);
      wr(`ASC_A_LCR, 8'h03);
      rd(`ASC_A_IER, 8'h0A);
      wr(`ASC_A_IER, 8'h00);
      modem_u.bit_clks = 32;
   endtask
   task automatic t_tx;
      int per;
      for (int i = 0; i < 6; i++) begin
         per = 2 * (16 * (6 + lcrs[i][1:0] + lcrs[i][3])
            + (lcrs[i][2] ? (lcrs[i][1:0] == 2'b00 ? 24 : 32) : 16));
         wr(`ASC_A_LCR, lcrs[i]);
         modem_u.cap_n = 6 + lcrs[i][1:0] + lcrs[i][3];
         modem_u.got_q.delete();
         modem_u.gap_q.delete();
         wr(`ASC_A_DATA, 8'(8'h96 + i));
         wr(`ASC_A_DATA, 8'(8'h3C - i));
         rd(`ASC_A_LSR, 8'h00);
         wr(`ASC_A_DATA, 8'hFF);
         wait_idle;
         chk_reg(rv, `ASC_LSR_RST);
         chk_val(16'(modem_u.got_q.size()), 16'h0002);
         chk_val(modem_u.got_q[0], frame(lcrs[i], 8'(8'h96 + i)));
         chk_val(modem_u.got_q[1], frame(lcrs[i], 8'(8'h3C - i)));
         chk_val(16'(modem_u.gap_q[1] >= per && modem_u.gap_q[1] <= per + 3), 16'h0001);
      end
      wr(`ASC_A_LCR, 8'h43);
      repeat (20) @(negedge clk);
      chk_val(16'(tx), 16'h0000);
      wr(`ASC_A_LCR, 8'h03);
      chk_val(16'(tx), 16'h0001);
   endtask
   task automatic t_modem;
      wr(`ASC_A_MCR, 8'h0B);
      chk_val(16'({dtr_n, rts_n, irq_oe}), 16'h0001);
      rd(`ASC_A_MSR, 8'h00);
      modem_u.set_lines(4'b0110);
      repeat (6) @(negedge clk);
      chk_val(16'(irq), 16'h0000);
      wr(`ASC_A_IER, 8'h08);
      rd(`ASC_A_ISR, `ASC_ISR_MS);
      chk_val(16'(irq), 16'h0001);
      rd(`ASC_A_MSR, 8'h99);
      rd(`ASC_A_MSR, 8'h90);
      rd(`ASC_A_ISR, `ASC_ISR_NONE);
      modem_u.set_lines(4'b0100);
      repeat (6) @(negedge clk);
      rd(`ASC_A_MSR, 8'hB2);
      modem_u.set_lines(4'hF);
      repeat (6) @(negedge clk);
      acc(1'b0, `ASC_A_MSR, 8'h00);
      modem_u.set_lines(4'hB);
      repeat (6) @(negedge clk);
      rd(`ASC_A_MSR, 8'h40);
      modem_u.set_lines(4'hF);
      repeat (6) @(negedge clk);
      rd(`ASC_A_MSR, 8'h04);
      wr(`ASC_A_IER, 8'h00);
   endtask
   task automatic t_rx;
      wr(`ASC_A_IER, 8'h05);
      modem_u.glitch(6);
      repeat (200) @(negedge clk);
      rd(`ASC_A_LSR, 8'h60);
      modem_u.send({6'h3F, 1'b1, 8'hA7, 1'b0}, 10);
      rd(`ASC_A_ISR, `ASC_ISR_RX);
      chk_val(16'({irq_oe, irq}), 16'h0003);
      rd(`ASC_A_LSR, 8'h61);
      rd(`ASC_A_DATA, 8'hA7);
      rd(`ASC_A_LSR, 8'h60);
      modem_u.send(16'({1'b1, 8'h11, 1'b0}), 10);
      modem_u.send(16'({1'b1, 8'h22, 1'b0}), 10);
      rd(`ASC_A_ISR, `ASC_ISR_LS);
      rd(`ASC_A_LSR, 8'h63);
      rd(`ASC_A_ISR, `ASC_ISR_RX);
      acc(1'b0, `ASC_A_DATA, 8'h00);
      modem_u.send(16'({1'b0, 8'h55, 1'b0}), 10);
      rd(`ASC_A_LSR, 8'h69);
      acc(1'b0, `ASC_A_DATA, 8'h00);
      modem_u.send(16'h0000, 10);
      acc(1'b0, `ASC_A_LSR, 8'h00);
      chk_val(16'(rv[4]), 16'h0001);
      acc(1'b0, `ASC_A_DATA, 8'h00);
      wr(`ASC_A_LCR, 8'h1B);
      modem_u.send(16'({1'b1, 1'b0, 8'h01, 1'b0}), 11);
      rd(`ASC_A_LSR, 8'h65);
      acc(1'b0, `ASC_A_DATA, 8'h00);
      wr(`ASC_A_LCR, 8'h03);
      wr(`ASC_A_IER, 8'h00);
   endtask
   task automatic t_txirq;
      wr(`ASC_A_IER, 8'h02);
      rd(`ASC_A_ISR, `ASC_ISR_TX);
      rd(`ASC_A_ISR, `ASC_ISR_NONE);
      wr(`ASC_A_IER, 8'h00);
   endtask
   task automatic t_loop;
      wr(`ASC_A_MCR, 8'h15);
      acc(1'b0, `ASC_A_MSR, 8'h00);
      chk_val(16'(rv[7:4]), 16'h0006);
      wr(`ASC_A_DATA, 8'hC3);
      repeat (40) @(negedge clk);
      chk_val(16'(tx), 16'h0001);
      wait_idle;
      rd(`ASC_A_DATA, 8'hC3);
      wr(`ASC_A_MCR, 8'h00);
   endtask
   initial begin
      srst = 1'b1;
      {cs_n, iow_n, ior_n} = 3'h7;
      addr = 3'h0;
      din = 8'h00;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_regs;
      t_div;
      t_tx;
      t_modem;
      t_rx;
      t_txirq;
      t_loop;
      finish_test;
   end
endmodule
